/* core/flash_guard_pkg.sv */
// Constants, field positions and types shared by the flash self-program guard
package flash_guard_pkg;
    // Register map, byte addresses on the 16-bit peripheral space
    localparam logic [15:0] MODE_CTRL_ADDR = 16'hffc4;
    localparam logic [15:0] CMD_ADDR       = 16'hffc0;
    localparam logic [15:0] STATUS_ADDR    = 16'hffc2;
    localparam logic [7:0]  PERIPH_PAGE    = 8'hff;
    // Unlock key and reset values
    localparam logic [7:0]  UNLOCK_KEY     = 8'ha5;
    localparam logic [7:0]  MODE_USER_RST  = 8'h08;
    localparam logic [7:0]  STATUS_RST     = 8'h00;
    localparam logic [7:0]  READ_ZERO      = 8'h00;
    // Field positions in mode control and status
    localparam int          LO_BIT         = 0;
    localparam int          HI_BIT         = 1;
    localparam int          PIN_BIT        = 2;
    localparam int          WED_BIT        = 3;
    localparam int          ERR_BIT        = 0;
    // Firmware entry and boot clusters (4 KB each)
    localparam logic [15:0] FW_ENTRY_ADDR  = 16'h8100;
    localparam int          CLUSTER_BIT    = 12;
    localparam logic [2:0]  BOOT_PAIR_TAG  = 3'h0;
    // Self-programming mode encodings
    typedef enum logic [1:0]
    {
        MODE_NORMAL   = 2'h0,
        MODE_FW_CALL  = 2'h1,
        MODE_BAD      = 2'h2,
        MODE_FW_FETCH = 2'h3
    } sp_mode_t;
    // Unlock sequence progress
    typedef enum logic [3:0]
    {
        ST_IDLE = 4'h1,
        ST_CMD  = 4'h2,
        ST_VAL  = 4'h4,
        ST_INV  = 4'h8
    } unlock_state_t;
endpackage

/* core/store_event_if.sv */
// Peripheral store events and unlock verdicts between top and tracker
`timescale 1ns/100ps
`default_nettype none
interface store_event_if;
    logic       st_valid;
    logic       st_cmd;
    logic       st_mode;
    logic [7:0] st_data;
    logic       commit;
    logic       fail;
    logic [7:0] commit_val;
    modport tracker
    (
        input  st_valid, st_cmd, st_mode, st_data,
        output commit, fail, commit_val
    );
    modport source
    (
        output st_valid, st_cmd, st_mode, st_data,
        input  commit, fail, commit_val
    );
endinterface
`default_nettype wire

/* core/unlock_tracker.sv */
// Four-store unlock sequence tracker for the mode control register
`timescale 1ns/100ps
`default_nettype none
module unlock_tracker
(
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    // Store events
    store_event_if.tracker        ev
);
    flash_guard_pkg::unlock_state_t state_reg;
    flash_guard_pkg::unlock_state_t state_next;
    logic [7:0]                   val_reg;
    logic                         key_ok;
    logic                         inv_ok;
    logic                         same_ok;
    logic                         other;

    assign key_ok  = ev.st_data == flash_guard_pkg::UNLOCK_KEY;
    assign inv_ok  = ev.st_data == ~val_reg;
    assign same_ok = ev.st_data == val_reg;
    assign other   = !ev.st_cmd && !ev.st_mode;
    assign ev.commit_val = val_reg;

    always_comb
    begin
        state_next = state_reg;
        ev.commit  = 1'b0;
        ev.fail    = 1'b0;
        if (ev.st_valid)
        begin
            case (state_reg)
                flash_guard_pkg::ST_IDLE:
                begin
                    ev.fail    = ev.st_mode || (ev.st_cmd && !key_ok);
                    state_next = (ev.st_cmd && key_ok) ? flash_guard_pkg::ST_CMD
                                                       : flash_guard_pkg::ST_IDLE;
                end
                flash_guard_pkg::ST_CMD:
                begin
                    ev.fail    = other || (ev.st_cmd && !key_ok);
                    state_next = ev.st_mode ? flash_guard_pkg::ST_VAL
                               : (ev.st_cmd && key_ok) ? flash_guard_pkg::ST_CMD
                               : flash_guard_pkg::ST_IDLE;
                end
                flash_guard_pkg::ST_VAL:
                begin
                    ev.fail    = !ev.st_mode || !inv_ok;
                    state_next = (ev.st_mode && inv_ok) ? flash_guard_pkg::ST_INV
                                                        : flash_guard_pkg::ST_IDLE;
                end
                flash_guard_pkg::ST_INV:
                begin
                    ev.fail    = !ev.st_mode || !same_ok;
                    ev.commit  = ev.st_mode && same_ok;
                    state_next = flash_guard_pkg::ST_IDLE;
                end
                default:
                begin
                    state_next = flash_guard_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            state_reg <= flash_guard_pkg::ST_IDLE;
            val_reg   <= flash_guard_pkg::READ_ZERO;
        end
        else
        begin
            state_reg <= state_next;
            if (ev.st_valid && ev.st_mode && state_reg == flash_guard_pkg::ST_CMD)
            begin
                val_reg <= ev.st_data;
            end
        end
    end
endmodule
`default_nettype wire

/* core/boot_swap_map.sv */
// Boot cluster exchange on the flash address path
`timescale 1ns/100ps
`default_nettype none
module boot_swap_map
(
    // Control
    input  wire logic        swap_en,
    // Address path
    input  wire logic [15:0] addr_in,
    output logic      [15:0] addr_out
);
    logic in_boot_pair;

    // Only the two lowest 4 KB clusters trade places
    assign in_boot_pair = addr_in[15:13] == flash_guard_pkg::BOOT_PAIR_TAG;
    assign addr_out = (swap_en && in_boot_pair)
                    ? (addr_in ^ (16'h0001 << flash_guard_pkg::CLUSTER_BIT))
                    : addr_in;
endmodule
`default_nettype wire

/* core/flash_self_program_guard.sv */
// Flash self-programming guard: mode control, unlock, error flag, boot swap
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Mode taken from bits 0 and 1
// - 00 fetches all flash; 01 allows firmware call
// - 11 fetches firmware ROM; only firmware sets it
// - Write/erase only with disable 0, pin 1
// - Bit 2 reads the mode pin level
// - Reset gives 08H user, 0CH on-board
// - High mode bit selects firmware address source
// - On-board mode ignores the mode bits
// - Unlock opens with A5H to command register
// - Value, inverse, value; only third commits
// - Broken sequence keeps register, flags error
// - Error flag sticky until software writes 0
// - Command store not after A5H sets error
// - Peripheral store elsewhere mid-sequence sets error
// - Second value not inverse sets error
// - Third value differing sets error
// - Reset clears status; command undefined
// - Boot flag swaps clusters at next reset
// - Swap exchanges cluster 0 and 1
module flash_self_program_guard
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Mode pins
    input  wire logic        flash_mode_pin,
    input  wire logic        onboard_mode_pin,
    // Firmware side
    input  wire logic        fw_mode_wr,
    input  wire logic [1:0]  fw_mode_val,
    input  wire logic [15:0] fw_flash_addr,
    input  wire logic        boot_flag,
    // CPU fetch side
    input  wire logic [15:0] cpu_addr,
    output logic      [15:0] flash_addr,
    output logic      [15:0] fw_entry_addr,
    output logic             fetch_all_flash,
    output logic             fw_call_enable,
    output logic             fw_rom_fetch,
    // Flash array control
    output logic             write_erase_enable,
    output logic             protection_error_flag,
    output logic             boot_swapped
);

    ////////////////////////////////////////////////////////////////////////////////////////

    // Address match on the register port
    function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
        hit = a == target;
    endfunction

    // Two-flop pin synchronisers
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic onb_meta_reg;
    logic onb_sync_reg;

    always_ff @(posedge clk_sys)
    begin
        pin_meta_reg <= flash_mode_pin;
        pin_sync_reg <= pin_meta_reg;
        onb_meta_reg <= onboard_mode_pin;
        onb_sync_reg <= onb_meta_reg;
    end

    ////////////////////////////////////////////////////////////////////////////////////////

    // Strap: operating mode caught once after reset release
    logic strap_taken_reg;
    logic onboard_reg;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            strap_taken_reg <= 1'b0;
            onboard_reg     <= 1'b0;
        end
        else if (!strap_taken_reg)
        begin
            strap_taken_reg <= 1'b1;
            onboard_reg     <= onb_sync_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////

    // Register port decode
    logic periph_st;
    logic wr_mode;
    logic wr_cmd;
    logic wr_status;
    logic rd_mode;
    logic rd_status;

    assign periph_st = reg_wr && reg_addr[15:8] == flash_guard_pkg::PERIPH_PAGE;
    assign wr_mode   = reg_wr && hit(reg_addr, flash_guard_pkg::MODE_CTRL_ADDR);
    assign wr_cmd    = reg_wr && hit(reg_addr, flash_guard_pkg::CMD_ADDR);
    assign wr_status = reg_wr && hit(reg_addr, flash_guard_pkg::STATUS_ADDR);
    assign rd_mode   = reg_rd && hit(reg_addr, flash_guard_pkg::MODE_CTRL_ADDR);
    assign rd_status = reg_rd && hit(reg_addr, flash_guard_pkg::STATUS_ADDR);

    ////////////////////////////////////////////////////////////////////////////////////////

    // Unlock tracker
    store_event_if ev ();

    assign ev.st_valid = periph_st;
    assign ev.st_cmd   = wr_cmd;
    assign ev.st_mode  = wr_mode;
    assign ev.st_data  = reg_wdata;

    unlock_tracker u_tracker
    (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .ev      (ev.tracker)
    );

    ////////////////////////////////////////////////////////////////////////////////////////

    // Mode control register: stored bits are disable, hi and lo
    logic       wed_reg;
    logic       wed_next;
    logic [1:0] mode_reg;
    logic [1:0] mode_next;
    logic [1:0] user_mode;

    // A user commit can never produce the firmware fetch code nor 10
    assign user_mode = {1'b0, ev.commit_val[flash_guard_pkg::LO_BIT]};

    always_comb
    begin
        wed_next  = wed_reg;
        mode_next = mode_reg;
        if (ev.commit)
        begin
            wed_next  = ev.commit_val[flash_guard_pkg::WED_BIT];
            mode_next = user_mode;
        end
        if (fw_mode_wr)
        begin
            mode_next = fw_mode_val;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            wed_reg  <= flash_guard_pkg::MODE_USER_RST[flash_guard_pkg::WED_BIT];
            mode_reg <= flash_guard_pkg::MODE_NORMAL;
        end
        else
        begin
            wed_reg  <= wed_next;
            mode_reg <= mode_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////

    // Status register: sticky protection error
    logic err_reg;
    logic err_next;
    logic err_clear;

    assign err_clear = wr_status && !reg_wdata[flash_guard_pkg::ERR_BIT];

    // Set beats a clear landing in the same cycle
    always_comb
    begin
        err_next = err_reg;
        if (err_clear)
        begin
            err_next = 1'b0;
        end
        if (ev.fail)
        begin
            err_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            err_reg <= flash_guard_pkg::STATUS_RST[flash_guard_pkg::ERR_BIT];
        end
        else
        begin
            err_reg <= err_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////

    // Readback, one cycle after the read strobe
    logic [7:0] mode_view;
    logic [7:0] status_view;
    logic [7:0] rdata_next;

    always_comb
    begin
        mode_view = flash_guard_pkg::READ_ZERO;
        mode_view[flash_guard_pkg::LO_BIT]  = mode_reg[0];
        mode_view[flash_guard_pkg::HI_BIT]  = mode_reg[1];
        mode_view[flash_guard_pkg::PIN_BIT] = pin_sync_reg;
        mode_view[flash_guard_pkg::WED_BIT] = wed_reg;
        status_view = flash_guard_pkg::READ_ZERO;
        status_view[flash_guard_pkg::ERR_BIT] = err_reg;
    end

    // Command register is write-only and reads as zero
    assign rdata_next = rd_mode   ? mode_view
                      : rd_status ? status_view
                      : flash_guard_pkg::READ_ZERO;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            reg_rdata <= flash_guard_pkg::READ_ZERO;
        end
        else
        begin
            reg_rdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////

    // Boot swap: flag sampled while reset is held
    logic swap_reg;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            swap_reg <= boot_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////

    // Effective mode and flash address source
    logic [1:0]  eff_mode;
    logic [15:0] src_addr;
    logic [15:0] mapped_addr;
    logic        we_next;

    assign eff_mode = onboard_reg ? flash_guard_pkg::MODE_NORMAL : mode_reg;
    assign src_addr = eff_mode[1] ? fw_flash_addr : cpu_addr;
    assign we_next  = !wed_reg && pin_sync_reg;

    boot_swap_map u_swap
    (
        .swap_en  (swap_reg),
        .addr_in  (src_addr),
        .addr_out (mapped_addr)
    );

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            flash_addr         <= 16'(flash_guard_pkg::READ_ZERO);
            fetch_all_flash    <= 1'b1;
            fw_call_enable     <= 1'b0;
            fw_rom_fetch       <= 1'b0;
            write_erase_enable <= 1'b0;
        end
        else
        begin
            flash_addr         <= mapped_addr;
            fetch_all_flash    <= eff_mode == flash_guard_pkg::MODE_NORMAL;
            fw_call_enable     <= eff_mode == flash_guard_pkg::MODE_FW_CALL;
            fw_rom_fetch       <= eff_mode == flash_guard_pkg::MODE_FW_FETCH;
            write_erase_enable <= we_next;
        end
    end

    assign fw_entry_addr         = flash_guard_pkg::FW_ENTRY_ADDR;
    assign protection_error_flag = err_reg;
    assign boot_swapped          = swap_reg;

endmodule
`default_nettype wire

/* verification/flash_guard_asserts.sv */
// Port-level assertion checker for the flash self-program guard
`timescale 1ns/100ps
`default_nettype none
module flash_guard_asserts
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // Pins and firmware
    input wire logic        flash_mode_pin,
    input wire logic        fw_mode_wr,
    input wire logic [15:0] fw_flash_addr,
    input wire logic [15:0] cpu_addr,
    // Observed outputs
    input wire logic [15:0] flash_addr,
    input wire logic [15:0] fw_entry_addr,
    input wire logic        fetch_all_flash,
    input wire logic        fw_call_enable,
    input wire logic        fw_rom_fetch,
    input wire logic        write_erase_enable,
    input wire logic        protection_error_flag,
    input wire logic        boot_swapped
);
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire logic cmd_st  = reg_wr && reg_addr == flash_guard_pkg::CMD_ADDR;
    wire logic mode_st = reg_wr && reg_addr == flash_guard_pkg::MODE_CTRL_ADDR;
    wire logic key_st  = cmd_st && reg_wdata == flash_guard_pkg::UNLOCK_KEY;
    wire logic clr_st  = reg_wr && reg_addr == flash_guard_pkg::STATUS_ADDR && !reg_wdata[0];
    wire logic stray_st = reg_wr && reg_addr[15:8] == flash_guard_pkg::PERIPH_PAGE && !mode_st
        && !cmd_st;
    wire logic mode_rd = reg_rd && reg_addr == flash_guard_pkg::MODE_CTRL_ADDR;
    // Expected address after the cluster exchange of the low 8 KB
    wire logic [15:0] cpu_exp = (boot_swapped && cpu_addr < 16'h2000) ? (cpu_addr ^ 16'h1000)
        : cpu_addr;
    wire logic [15:0] fw_exp = (boot_swapped && fw_flash_addr < 16'h2000)
        ? (fw_flash_addr ^ 16'h1000) : fw_flash_addr;
    sequence s_key_val;
        key_st ##1 mode_st;
    endsequence
    sequence s_key_val_inv;
        s_key_val ##1 (mode_st && reg_wdata == ~$past(reg_wdata));
    endsequence
    sequence s_unlock;
        s_key_val_inv ##1 (mode_st && reg_wdata == $past(reg_wdata, 2) && !fw_mode_wr);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_read_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    a_entry_addr_fixed: assert property (fw_entry_addr == flash_guard_pkg::FW_ENTRY_ADDR)
        else $error("firmware entry address wrong");
    a_pin_blocks_write: assert property (!flash_mode_pin [*4] |=> !write_erase_enable)
        else $error("write enabled with mode pin low");
    a_mode_single_out: assert property ($onehot0({fetch_all_flash, fw_call_enable, fw_rom_fetch}))
        else $error("more than one mode output active");
    a_bad_key_error: assert property (cmd_st && !key_st |=> protection_error_flag)
        else $error("bad command store did not flag error");
    a_error_sticky: assert property (protection_error_flag && !clr_st |=> protection_error_flag)
        else $error("error flag dropped without clear");
    a_commit_value: assert property (s_unlock ##1 mode_rd |=> reg_rdata[3] == $past(reg_wdata[3], 2)
        && reg_rdata[1:0] == {1'b0, $past(reg_wdata[0], 2)})
        else $error("unlock commit value wrong");
    a_bad_inverse: assert property (s_key_val ##1 (mode_st && reg_wdata != ~$past(reg_wdata))
        |=> protection_error_flag)
        else $error("bad inverse did not flag error");
    a_bad_third: assert property (s_key_val_inv ##1 (mode_st && reg_wdata != $past(reg_wdata, 2))
        |=> protection_error_flag)
        else $error("bad third value did not flag error");
    a_stray_store: assert property (key_st ##1 stray_st |=> protection_error_flag)
        else $error("stray store did not flag error");
    a_cpu_addr_path: assert property ((fetch_all_flash || fw_call_enable) [*4]
        |-> flash_addr == $past(cpu_exp))
        else $error("flash address not from cpu bus");
    a_fw_addr_path: assert property (fw_rom_fetch [*4] |-> flash_addr == $past(fw_exp))
        else $error("flash address not from firmware");
endmodule
bind flash_self_program_guard flash_guard_asserts flash_guard_asserts_inst
(
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_mode_pin(flash_mode_pin),
    .fw_mode_wr(fw_mode_wr), .fw_flash_addr(fw_flash_addr), .cpu_addr(cpu_addr),
    .flash_addr(flash_addr), .fw_entry_addr(fw_entry_addr), .fetch_all_flash(fetch_all_flash),
    .fw_call_enable(fw_call_enable), .fw_rom_fetch(fw_rom_fetch),
    .write_erase_enable(write_erase_enable), .protection_error_flag(protection_error_flag),
    .boot_swapped(boot_swapped)
);
`default_nettype wire

/* verification/flash_self_program_guard_test.sv */
// Self-checking bench for the flash self-program guard
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module flash_self_program_guard_test;
    localparam logic [15:0] MODE = flash_guard_pkg::MODE_CTRL_ADDR;
    localparam logic [15:0] CMD  = flash_guard_pkg::CMD_ADDR;
    localparam logic [15:0] STAT = flash_guard_pkg::STATUS_ADDR;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        flash_mode_pin = 1'b0;
    logic        onboard_mode_pin = 1'b0;
    logic        fw_mode_wr = 1'b0;
    logic [1:0]  fw_mode_val = 2'h0;
    logic [15:0] fw_flash_addr = 16'h4321;
    logic        boot_flag = 1'b0;
    logic [15:0] cpu_addr = 16'h3456;
    wire logic [7:0]  reg_rdata;
    wire logic [15:0] flash_addr;
    wire logic [15:0] fw_entry_addr;
    wire logic        fetch_all_flash;
    wire logic        fw_call_enable;
    wire logic        fw_rom_fetch;
    wire logic        write_erase_enable;
    wire logic        protection_error_flag;
    wire logic        boot_swapped;
    int          errors = 0;
    int          checked = 0;
    int          cyc = 0;
    // Mode values never carry the prohibited 10 encoding
    logic [7:0]  vals [4] = '{8'h01, 8'h03, 8'h00, 8'h09};
    flash_self_program_guard flash_self_program_guard_inst
    (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .flash_mode_pin(flash_mode_pin), .onboard_mode_pin(onboard_mode_pin),
        .fw_mode_wr(fw_mode_wr), .fw_mode_val(fw_mode_val), .fw_flash_addr(fw_flash_addr),
        .boot_flag(boot_flag), .cpu_addr(cpu_addr), .flash_addr(flash_addr),
        .fw_entry_addr(fw_entry_addr), .fetch_all_flash(fetch_all_flash),
        .fw_call_enable(fw_call_enable), .fw_rom_fetch(fw_rom_fetch),
        .write_erase_enable(write_erase_enable), .protection_error_flag(protection_error_flag),
        .boot_swapped(boot_swapped)
    );
    always #2.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Generous ceiling; the full run needs well under a thousand cycles
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            give_verdict();
        end
    end
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            reg_wr     <= 1'b0;
            reg_rd     <= 1'b0;
            fw_mode_wr <= 1'b0;
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        reg_addr  <= a;
        reg_wdata <= d;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b1;
        reg_addr <= a;
        idle(1);
        #1;
        `CHK("reg_rdata", e, reg_rdata)
    endtask
    task automatic unlock(input logic [7:0] v);
        wr(CMD, flash_guard_pkg::UNLOCK_KEY);
        wr(MODE, v);
        wr(MODE, ~v);
        wr(MODE, v);
    endtask
    // Flag must be up, register untouched, then a zero write clears it
    task automatic err_chk(input logic [7:0] m);
        idle(2);
        `CHK("protection_error_flag", 1'b1, protection_error_flag)
        rd(MODE, m);
        wr(STAT, 8'h00);
        idle(2);
        `CHK("protection_error_flag", 1'b0, protection_error_flag)
    endtask
    task automatic do_reset();
        rst_b <= 1'b0;
        idle(3);
        rst_b <= 1'b1;
        idle(2);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset();
        rd(MODE, 8'h08);
        rd(STAT, flash_guard_pkg::STATUS_RST);
        rd(16'h1234, 8'h00);
        `CHK("fetch_all_flash", 1'b1, fetch_all_flash)
        `CHK("fw_entry_addr", 16'h8100, fw_entry_addr)
        `CHK("write_erase_enable", 1'b0, write_erase_enable)
        $display("test reset_values done");
        flash_mode_pin <= 1'b1;
        foreach (vals[i])
        begin
            unlock(vals[i]);
            rd(MODE, {4'h0, vals[i][3], 2'h2, vals[i][0]});
            idle(2);
            `CHK("fw_call_enable", vals[i][0], fw_call_enable)
            `CHK("fetch_all_flash", ~vals[i][0], fetch_all_flash)
            `CHK("fw_rom_fetch", 1'b0, fw_rom_fetch)
            `CHK("write_erase_enable", ~vals[i][3], write_erase_enable)
        end
        flash_mode_pin <= 1'b0;
        idle(5);
        `CHK("write_erase_enable", 1'b0, write_erase_enable)
        `CHK("flash_addr", 16'h3456, flash_addr)
        rd(MODE, 8'h09);
        $display("test unlock_modes done");
        wr(CMD, 8'h5a);
        err_chk(8'h09);
        wr(CMD, 8'ha5);
        wr(16'hff10, 8'h00);
        err_chk(8'h09);
        wr(CMD, 8'ha5);
        wr(MODE, 8'h01);
        wr(MODE, 8'h01);
        err_chk(8'h09);
        wr(CMD, 8'ha5);
        wr(MODE, 8'h01);
        wr(MODE, 8'hfe);
        wr(MODE, 8'h00);
        err_chk(8'h09);
        wr(MODE, 8'h01);
        err_chk(8'h09);
        wr(CMD, 8'h5a);
        unlock(8'h09);
        err_chk(8'h09);
        unlock(8'h01);
        wr(MODE, 8'h00);
        wr(MODE, 8'hff);
        wr(MODE, 8'h00);
        err_chk(8'h01);
        $display("test unlock_errors done");
        wr(CMD, 8'ha5);
        rd(STAT, 8'h00);
        wr(16'h1000, 8'h77);
        wr(MODE, 8'h01);
        wr(MODE, 8'hfe);
        wr(MODE, 8'h01);
        idle(2);
        `CHK("protection_error_flag", 1'b0, protection_error_flag)
        rd(MODE, 8'h01);
        $display("test tracker_filter done");
        fw_mode_val <= 2'h3;
        fw_mode_wr  <= 1'b1;
        idle(4);
        `CHK("fw_rom_fetch", 1'b1, fw_rom_fetch)
        `CHK("flash_addr", 16'h4321, flash_addr)
        rd(MODE, 8'h03);
        fw_mode_val <= 2'h0;
        fw_mode_wr  <= 1'b1;
        cpu_addr    <= 16'h0123;
        idle(4);
        `CHK("flash_addr", 16'h0123, flash_addr)
        $display("test firmware_mode done");
        boot_flag        <= 1'b1;
        onboard_mode_pin <= 1'b1;
        flash_mode_pin   <= 1'b1;
        do_reset();
        `CHK("boot_swapped", 1'b1, boot_swapped)
        rd(MODE, 8'h0c);
        `CHK("flash_addr", 16'h1123, flash_addr)
        cpu_addr <= 16'h1abc;
        idle(3);
        `CHK("flash_addr", 16'h0abc, flash_addr)
        unlock(8'h01);
        rd(MODE, 8'h05);
        idle(2);
        `CHK("fetch_all_flash", 1'b1, fetch_all_flash)
        `CHK("fw_call_enable", 1'b0, fw_call_enable)
        $display("test boot_swap_onboard done");
        give_verdict();
    end
endmodule
`default_nettype wire
